// File: hw/strength_pwm_pkg.sv
package strength_pwm_pkg;

  // Clock and pulse period
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PULSE_PERIOD_NS = 64000;
  localparam int          PERIOD_CYCLES_INT = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [12:0] PERIOD_CYCLES = 13'(PERIOD_CYCLES_INT);

  // Duty resolution: 445 steps of about 144 ns each
  localparam int          STEP_NS = 144;
  localparam logic [8:0]  DUTY_STEPS = 9'h1bd;
  localparam logic [8:0]  LAST_STEP = 9'h1bc;
  localparam logic [8:0]  STEP_ZERO = 9'h000;
  localparam logic [12:0] ACC_ZERO = 13'h0000;

  // Margin to duty mapping, in duty steps
  localparam int          ZERO_DB_STEPS = 107;
  localparam int          SLOPE_NUM = 121;
  localparam int          SLOPE_SHIFT = 4;
  localparam int          LOW_SLOPE = 4;
  localparam int          MIN_ACTIVE_STEPS = 5;
  localparam int          FULL_STEPS = 445;
  localparam logic [8:0]  DUTY_RESET = 9'h000;

  // Hold timer
  localparam int          HOLD_UNIT_MS = 100;
  localparam int          HOLD_UNIT_CYCLES_DEF = HOLD_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [7:0]  HOLD_OFF = 8'h00;
  localparam logic [7:0]  HOLD_FOREVER = 8'hff;
  localparam logic [7:0]  HOLD_DEFAULT = 8'h28;
  localparam logic [7:0]  HOLD_ONE = 8'h01;

  typedef enum logic [1:0] {
    IND_IDLE,
    IND_HOLD,
    IND_FOREVER
  } ind_state_t;

endpackage

// File: hw/margin_to_duty.sv
`timescale 1ns/1ns
`default_nettype none
module margin_to_duty (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic signed [7:0] margin_db,
  output logic [8:0]       duty
);
  import strength_pwm_pkg::*;

  // Linear fit through 0/10/20/30 dB points, saturating at full on
  function automatic logic [8:0] steps_for(input logic signed [7:0] m);
    int v;
    v = ZERO_DB_STEPS;
    if (m <= 0) begin
      v = ZERO_DB_STEPS + LOW_SLOPE * int'(m);
      if (v < MIN_ACTIVE_STEPS) begin
        v = MIN_ACTIVE_STEPS;
      end
    end else begin
      v = ZERO_DB_STEPS + ((SLOPE_NUM * int'(m)) >>> SLOPE_SHIFT);
      if (v > FULL_STEPS) begin
        v = FULL_STEPS;
      end
    end
    return v[8:0];
  endfunction

  // Margin is relative to sensitivity, never absolute power
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      duty <= DUTY_RESET;
    end else if (load) begin
      duty <= steps_for(margin_db);
    end
  end

  property p_map_points;
    @(posedge mclk) disable iff (!reset_n)
    load && (margin_db == 8'sh0a) |=> duty == 9'h0b6;
  endproperty
  a_map_points: assert property (p_map_points)
    else $error("10 dB margin not mapped to 41 percent");

  property p_low_band;
    @(posedge mclk) disable iff (!reset_n)
    load && (margin_db <= 8'sh00) |=> (duty >= 9'h005) && (duty <= 9'h06b);
  endproperty
  a_low_band: assert property (p_low_band)
    else $error("Below sensitivity duty outside 1 to 24 percent");

endmodule // margin_to_duty
`default_nettype wire

// File: hw/signal_strength_pwm.sv
// Operation
// - Pulse period fixed at 64 us
// - Period split into 445 duty steps
// - Active duty spans 1 to 100 percent
// - Inactive indication holds output constantly low
// - At or below sensitivity gives 1-24 percent
// - 10/20/30 dB map to 41/58/75 percent
// - Duty tracks margin both above and below sensitivity
// - Hold settings 0x01-0xFE count 100 ms units
// - Hold expiry forces zero until next packet
// - Output zero after power-up until packet
// - Setting 0xFF never times out
`timescale 1ns/1ns
`default_nettype none
module signal_strength_pwm #(
  parameter int HOLD_UNIT_CYCLES = strength_pwm_pkg::HOLD_UNIT_CYCLES_DEF
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        packet_valid,
  input  wire logic signed [7:0] packet_margin,
  input  wire logic [7:0]  strength_hold_time,
  output logic             strength_pulse_output
);
  import strength_pwm_pkg::*;

  localparam int TW = (HOLD_UNIT_CYCLES > 1) ? $clog2(HOLD_UNIT_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(HOLD_UNIT_CYCLES - 1);
  localparam logic [TW-1:0] TICK_ZERO = '0;
  localparam logic [TW-1:0] TICK_ONE  = TW'(1);
  localparam logic [31:0]   SPAN_ZERO = 32'h0000_0000;
  localparam logic [31:0]   SPAN_ONE  = 32'h0000_0001;

  logic [12:0]      phase_acc;
  logic [8:0]       step;
  logic [8:0]       duty;
  logic [TW-1:0]    tick_count;
  logic             unit_tick;
  logic [7:0]       hold_left;
  ind_state_t       state;
  logic             accept;
  logic [13:0]      next_acc;

  // Hold setting of zero never lets a packet through
  assign accept = packet_valid && (strength_hold_time != HOLD_OFF);

  margin_to_duty u_map (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .load      (accept),
    .margin_db (packet_margin),
    .duty      (duty)
  );

  // Fractional step clock: 445 steps land exactly on 6400 cycles,
  // which avoids the drift a rounded 14-cycle step would give
  always_comb begin
    next_acc = {1'b0, phase_acc} + {5'h00, DUTY_STEPS};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_acc <= ACC_ZERO;
      step      <= STEP_ZERO;
    end else if (next_acc >= {1'b0, PERIOD_CYCLES}) begin
      phase_acc <= 13'(next_acc - {1'b0, PERIOD_CYCLES});
      step      <= (step == LAST_STEP) ? STEP_ZERO : step + 9'h001;
    end else begin
      phase_acc <= next_acc[12:0];
    end
  end

  // 100 ms prescaler, realigned to each accepted packet
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_count <= TICK_ZERO;
      unit_tick  <= 1'b0;
    end else if (accept) begin
      tick_count <= TICK_ZERO;
      unit_tick  <= 1'b0;
    end else if (tick_count == TICK_LAST) begin
      tick_count <= TICK_ZERO;
      unit_tick  <= 1'b1;
    end else begin
      tick_count <= tick_count + TICK_ONE;
      unit_tick  <= 1'b0;
    end
  end

  // Indication state; a packet in the expiry cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= IND_IDLE;
      hold_left <= HOLD_OFF;
    end else if (accept) begin
      hold_left <= strength_hold_time;
      if (strength_hold_time == HOLD_FOREVER) begin
        state <= IND_FOREVER;
      end else begin
        state <= IND_HOLD;
      end
    end else begin
      unique case (state)
        IND_IDLE: begin
          hold_left <= HOLD_OFF;
        end
        IND_HOLD: begin
          if (unit_tick) begin
            hold_left <= hold_left - HOLD_ONE;
            if (hold_left == HOLD_ONE) begin
              state <= IND_IDLE;
            end
          end
        end
        IND_FOREVER: begin
          state <= IND_FOREVER;
        end
        // Spare state code recovers to idle
        default: begin
          state     <= IND_IDLE;
          hold_left <= HOLD_OFF;
        end
      endcase
    end
  end

  // Rising edge at step zero, high while step is below duty
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strength_pulse_output <= 1'b0;
    end else if (state == IND_IDLE) begin
      strength_pulse_output <= 1'b0;
    end else begin
      strength_pulse_output <= (step < duty);
    end
  end

  // Helper logic for the checks below
  logic [12:0] wrap_gap;
  logic        seen_packet;
  logic        wrap;
  logic [7:0]  hold_set;
  logic [31:0] hold_span;

  assign wrap = (step == LAST_STEP) && (next_acc >= {1'b0, PERIOD_CYCLES});

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrap_gap <= ACC_ZERO;
    end else if (wrap) begin
      wrap_gap <= ACC_ZERO;
    end else begin
      wrap_gap <= wrap_gap + 13'h0001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seen_packet <= 1'b0;
    end else if (accept) begin
      seen_packet <= 1'b1;
    end
  end

  // Cycles since the last packet, for the hold length check
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_set  <= HOLD_OFF;
      hold_span <= SPAN_ZERO;
    end else if (accept) begin
      hold_set  <= strength_hold_time;
      hold_span <= SPAN_ZERO;
    end else begin
      hold_span <= hold_span + SPAN_ONE;
    end
  end

  property p_period;
    @(posedge mclk) disable iff (!reset_n)
    wrap |-> wrap_gap == 13'h18ff;
  endproperty
  a_period: assert property (p_period)
    else $error("Pulse period is not 6400 cycles");

  property p_step_range;
    @(posedge mclk) disable iff (!reset_n)
    step <= 9'h1bc;
  endproperty
  a_step_range: assert property (p_step_range)
    else $error("Duty step index beyond 444");

  property p_active_duty;
    @(posedge mclk) disable iff (!reset_n)
    (state != IND_IDLE) && (duty >= 9'h06b) |-> duty <= 9'h1bd;
  endproperty
  a_active_duty: assert property (p_active_duty)
    else $error("Active duty above full period");

  property p_idle_low;
    @(posedge mclk) disable iff (!reset_n)
    (state == IND_IDLE) |=> !strength_pulse_output;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("Output high while indication inactive");

  property p_expire;
    @(posedge mclk) disable iff (!reset_n)
    (state == IND_HOLD) && unit_tick && (hold_left == 8'h01) && !accept
      |=> (state == IND_IDLE) ##1 !strength_pulse_output;
  endproperty
  a_expire: assert property (p_expire)
    else $error("Hold expiry did not force output low");

  property p_powerup;
    @(posedge mclk) disable iff (!reset_n)
    !seen_packet && !$past(seen_packet) |-> !strength_pulse_output;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("Output active before first packet");

  property p_forever;
    @(posedge mclk) disable iff (!reset_n)
    ((state == IND_FOREVER) || accept) && (!accept || (strength_hold_time == 8'hff))
      |=> state == IND_FOREVER;
  endproperty
  a_forever: assert property (p_forever)
    else $error("Permanent setting left the active state");

  property p_restart;
    @(posedge mclk) disable iff (!reset_n)
    accept |=> (hold_left == $past(strength_hold_time)) && (state != IND_IDLE)
      && (tick_count == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("Packet did not restart the hold");

  property p_hold_zero;
    @(posedge mclk) disable iff (!reset_n)
    (state == IND_IDLE) && packet_valid && (strength_hold_time == 8'h00)
      |=> state == IND_IDLE;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("Zero hold setting activated output");

  property p_tick_spacing;
    @(posedge mclk) disable iff (!reset_n)
    unit_tick |-> $past(tick_count) == TICK_LAST;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("Hold unit tick at wrong spacing");

  // A mid-period rise is legal only right after a packet moves duty
  property p_rise_at_zero;
    @(posedge mclk) disable iff (!reset_n)
    $rose(strength_pulse_output) && !$past(accept, 2) |-> $past(step) == STEP_ZERO;
  endproperty
  a_rise_at_zero: assert property (p_rise_at_zero)
    else $error("Pulse rose away from step zero");

  property p_full_on;
    @(posedge mclk) disable iff (!reset_n)
    (state != IND_IDLE) && (duty == DUTY_STEPS) |=> strength_pulse_output;
  endproperty
  a_full_on: assert property (p_full_on)
    else $error("Full duty did not hold output high");

  property p_step_zero_high;
    @(posedge mclk) disable iff (!reset_n)
    (state != IND_IDLE) && (step == STEP_ZERO) |=> strength_pulse_output;
  endproperty
  a_step_zero_high: assert property (p_step_zero_high)
    else $error("Active output missing its minimum pulse");

  property p_idle_stays;
    @(posedge mclk) disable iff (!reset_n)
    (state == IND_IDLE) && !accept |=> state == IND_IDLE;
  endproperty
  a_idle_stays: assert property (p_idle_stays)
    else $error("Indication woke without a packet");

  property p_hold_steady;
    @(posedge mclk) disable iff (!reset_n)
    (state == IND_HOLD) && !accept && !unit_tick |=> $stable(hold_left);
  endproperty
  a_hold_steady: assert property (p_hold_steady)
    else $error("Hold count moved without a unit tick");

  property p_hold_length;
    @(posedge mclk) disable iff (!reset_n)
    (state == IND_HOLD) && unit_tick && (hold_left == HOLD_ONE) && !accept
      |-> hold_span == 32'(hold_set) * 32'(HOLD_UNIT_CYCLES);
  endproperty
  a_hold_length: assert property (p_hold_length)
    else $error("Hold expired after the wrong number of cycles");

  property p_refused_duty;
    @(posedge mclk) disable iff (!reset_n)
    packet_valid && (strength_hold_time == HOLD_OFF) |=> $stable(duty);
  endproperty
  a_refused_duty: assert property (p_refused_duty)
    else $error("Refused packet changed the duty");

endmodule // signal_strength_pwm
`default_nettype wire

// File: hw/unused_placeholder_none.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: tb/radio_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module radio_rx_model (
  input  wire logic        mclk,
  output logic             packet_valid,
  output logic signed [7:0] packet_margin
);
  initial begin
    packet_valid  = 1'b0;
    packet_margin = 8'sh00;
  end
  // Margin line scrambled between packets so stale values never look valid
  task automatic send(input logic signed [7:0] m);
    @(posedge mclk);
    packet_valid  <= 1'b1;
    packet_margin <= m;
    @(posedge mclk);
    packet_valid  <= 1'b0;
    packet_margin <= ~m;
  endtask
endmodule // radio_rx_model
`default_nettype wire

// File: tb/tb_signal_strength_pwm.sv
`timescale 1ns/1ns
`default_nettype none
module tb_signal_strength_pwm;
  import strength_pwm_pkg::*;
  localparam int UNIT  = 20;
  localparam int PER   = 6400;
  localparam int LIMIT = 90000;
  logic              mclk;
  logic              reset_n;
  logic              packet_valid;
  logic signed [7:0] packet_margin;
  logic [7:0]        strength_hold_time;
  logic              strength_pulse_output;
  int                err_count = 0;
  int                comparisons = 0;
  int                cycles = 0;

  signal_strength_pwm #(.HOLD_UNIT_CYCLES(UNIT)) signal_strength_pwm_i (
    .mclk(mclk), .reset_n(reset_n), .packet_valid(packet_valid),
    .packet_margin(packet_margin), .strength_hold_time(strength_hold_time),
    .strength_pulse_output(strength_pulse_output));
  radio_rx_model radio_rx_model_i (
    .mclk(mclk), .packet_valid(packet_valid), .packet_margin(packet_margin));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] time=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Window tolerance: free running phase makes counts land within one step
  function automatic logic [31:0] near(input logic [31:0] seen, input int exp, input int tol);
    return (int'(seen) >= exp - tol && int'(seen) <= exp + tol) ? 32'(exp) : seen;
  endfunction
  task automatic set_hold(input logic [7:0] v);
    @(posedge mclk);
    strength_hold_time <= v;
  endtask
  // Output follows one cycle after the taking edge
  task automatic pkt(input logic signed [7:0] m);
    radio_rx_model_i.send(m);
    repeat (2) @(negedge mclk);
  endtask
  task automatic count_high(input int n, output logic [31:0] hi);
    hi = 0;
    repeat (n) begin
      @(negedge mclk);
      if (strength_pulse_output === 1'b1) hi++;
    end
  endtask
  task automatic wait_level(input logic v);
    int n;
    n = 0;
    while (strength_pulse_output !== v && n < PER) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic t_power_up();
    logic [31:0] hi;
    count_high(PER, hi);
    check(hi, 32'h0);
    $display("test power_up done");
  endtask
  task automatic t_hold();
    logic [31:0] hi;
    set_hold(8'h0a);
    pkt(8'sh3c);
    count_high(150, hi);
    check(hi, 32'd150);
    pkt(8'sh3c);
    count_high(150, hi);
    check(hi, 32'd150);
    repeat (60) @(negedge mclk);
    count_high(PER, hi);
    check(hi, 32'h0);
    set_hold(HOLD_OFF);
    pkt(8'sh3c);
    count_high(PER, hi);
    check(hi, 32'h0);
    $display("test hold done");
  endtask
  task automatic t_duty();
    logic signed [7:0] m [5] = '{8'sh0a, 8'sh14, 8'sh1e, 8'sh3c, 8'sh00};
    int                exp [5] = '{2624, 3712, 4800, 6400, 1536};
    logic [31:0]       hi;
    set_hold(HOLD_FOREVER);
    for (int i = 0; i < 5; i++) begin
      pkt(m[i]);
      count_high(PER, hi);
      check(near(hi, exp[i], (i == 3) ? 0 : 64), 32'(exp[i]));
    end
    pkt(8'shf6);
    count_high(PER, hi);
    check(32'(hi >= 64 && hi <= 1536), 32'h1);
    $display("test duty done");
  endtask
  task automatic t_period();
    int t0;
    pkt(8'sh14);
    wait_level(1'b0);
    wait_level(1'b1);
    t0 = cycles;
    wait_level(1'b0);
    wait_level(1'b1);
    check(near(32'(cycles - t0), PER, 16), 32'(PER));
    $display("test period done");
  endtask
  task automatic t_expiry();
    logic [31:0] hi;
    set_hold(8'h02);
    pkt(8'sh3c);
    count_high(3 * UNIT, hi);
    check(near(hi, 2 * UNIT, 2), 32'(2 * UNIT));
    check(32'(strength_pulse_output), 32'h0);
    $display("test expiry done");
  endtask

  initial begin
    reset_n = 1'b0;
    strength_hold_time = HOLD_DEFAULT;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    t_power_up();
    t_hold();
    t_duty();
    t_period();
    t_expiry();
    summarize();
  end
endmodule // tb_signal_strength_pwm
`default_nettype wire
